//--- verilog/dcpw_map.vh
// constants for the dual controller page writer: timing, layout, opcodes
// assumes the includer runs on core_clk at 20 MHz
`ifndef DCPW_MAP_VH
`define DCPW_MAP_VH
// timing
`define DCPW_CLK_PERIOD_NS 50
`define DCPW_CYCLE_NS 1000
`define DCPW_RESET_NS 2000
`define DCPW_BUSY_CYC ((`DCPW_CYCLE_NS+`DCPW_CLK_PERIOD_NS-1)/`DCPW_CLK_PERIOD_NS)
`define DCPW_RESET_CYC ((`DCPW_RESET_NS+`DCPW_CLK_PERIOD_NS-1)/`DCPW_CLK_PERIOD_NS)
// memory layout
`define DCPW_COLS 7'h50
`define DCPW_COL_LAST 7'h4F
`define DCPW_VIS_COLS 61
`define DCPW_RAM_WORDS 320
`define DCPW_PAGE_BITS 8
`define DCPW_LAST_ROW_32 5'h1F
`define DCPW_LAST_ROW_16 5'h0F
// instruction opcodes, upper bits only
`define DCPW_OP_DISP 7'h57
`define DCPW_OP_ADC 7'h50
`define DCPW_OP_DUTY 7'h54
`define DCPW_OP_PAGE 6'h2E
`define DCPW_OP_START 3'h6
// status byte bit positions
`define DCPW_ST_BUSY 7
`define DCPW_ST_ADC 6
`define DCPW_ST_OFF 5
`define DCPW_ST_RST 4
// role straps as wired on the board
`define DCPW_LEFT_STRAP 1'b1
`define DCPW_RIGHT_STRAP 1'b0
`endif

//--- verilog/dcpw_bus_sync.v
// bus pin conditioning: samples the host pins, forms end-of-strobe pulses
// assumes all pins are synchronous to core_clk
`timescale 1ns/10ps
module dcpw_bus_sync (
    input wire core_clk,
    input wire rst_n,
    input wire left_half_select_n,
    input wire right_half_select_n,
    input wire register_select,
    input wire rd_n,
    input wire wr_n,
    input wire [7:0] data_in,
    input wire edge_reset_input,
    input wire ext_clk,
    output wire wr_pulse,
    output wire rd_pulse,
    output wire res_fall,
    output wire cl_rise,
    output reg [1:0] sel_s_reg,
    output reg rs_s_reg,
    output reg rd_s_reg,
    output reg [1:0] sel_d_reg,
    output reg rs_d_reg,
    output reg [7:0] din_d_reg
);
    // ****************************************
    // sampling stages
    // ****************************************
    reg wr_s_reg;
    reg wr_d_reg;
    reg rd_d_reg;
    reg res_s_reg;
    reg res_d_reg;
    reg cl_s_reg;
    reg cl_d_reg;
    reg [7:0] din_s_reg;

    // two stages so the second holds values seen while a strobe was low
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_s_reg <= 1'b1;
            wr_d_reg <= 1'b1;
            rd_s_reg <= 1'b1;
            rd_d_reg <= 1'b1;
            res_s_reg <= 1'b0;
            res_d_reg <= 1'b0;
            cl_s_reg <= 1'b0;
            cl_d_reg <= 1'b0;
            sel_s_reg <= 2'h0;
            sel_d_reg <= 2'h0;
            rs_s_reg <= 1'b0;
            rs_d_reg <= 1'b0;
            din_s_reg <= 8'h00;
            din_d_reg <= 8'h00;
        end else begin
            wr_s_reg <= wr_n;
            wr_d_reg <= wr_s_reg;
            rd_s_reg <= rd_n;
            rd_d_reg <= rd_s_reg;
            res_s_reg <= edge_reset_input;
            res_d_reg <= res_s_reg;
            cl_s_reg <= ext_clk;
            cl_d_reg <= cl_s_reg;
            sel_s_reg <= {~right_half_select_n, ~left_half_select_n};
            sel_d_reg <= sel_s_reg;
            rs_s_reg <= register_select;
            rs_d_reg <= rs_s_reg;
            din_s_reg <= data_in;
            din_d_reg <= din_s_reg;
        end
    end

    // ****************************************
    // edge pulses
    // ****************************************
    // strobes act on their rising (trailing) edge
    assign wr_pulse = wr_s_reg & ~wr_d_reg;
    assign rd_pulse = rd_s_reg & ~rd_d_reg;
    assign res_fall = ~res_s_reg & res_d_reg; // high to low starts reset
    assign cl_rise = cl_s_reg & ~cl_d_reg;
endmodule // dcpw_bus_sync

//--- verilog/dcpw_top.v
// two column controller halves forming a 122 x 32 page written display
// assumes a host on the parallel bus and a slow external scan clock
`timescale 1ns/10ps
`include "dcpw_map.vh"
module dcpw_top (
    input wire core_clk,
    input wire rst_n,
    input wire left_half_select_n,
    input wire right_half_select_n,
    input wire register_select,
    input wire rd_n,
    input wire wr_n,
    input wire [7:0] data_in,
    input wire edge_reset_input,
    input wire ext_clk,
    output reg [7:0] data_out_reg,
    output reg data_oe_reg,
    output reg [4:0] common_row_reg,
    output reg row_strobe_reg,
    output reg [121:0] seg_out_reg
);
    // ****************************************
    // constants and shared decode
    // ****************************************
    // timer loads cut to the busy counter width on purpose
    localparam [31:0] BUSY_CYC_W = `DCPW_BUSY_CYC;
    localparam [31:0] RESET_CYC_W = `DCPW_RESET_CYC;
    localparam [5:0] BUSY_LOAD = BUSY_CYC_W[5:0];
    localparam [5:0] RESET_LOAD = RESET_CYC_W[5:0];

    // page and column to memory word index
    function [8:0] ram_idx;
        input [1:0] pg;
        input [6:0] c;
        begin
            ram_idx = ({7'h00, pg} * {2'h0, `DCPW_COLS}) + {2'h0, c};
        end
    endfunction

    wire wr_pulse;
    wire rd_pulse;
    wire res_fall;
    wire cl_rise;
    wire [1:0] sel_s;
    wire rs_s;
    wire rd_s;
    wire [1:0] sel_d;
    wire rs_d;
    wire [7:0] din_d;
    wire [15:0] rd_bus;
    wire [9:0] row_bus;
    wire [1:0] tick_bus;
    wire [121:0] seg_bus;
    wire [4:0] scan_row;

    // ****************************************
    // pin conditioning
    // ****************************************
    dcpw_bus_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .left_half_select_n(left_half_select_n),
        .right_half_select_n(right_half_select_n),
        .register_select(register_select),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .data_in(data_in),
        .edge_reset_input(edge_reset_input),
        .ext_clk(ext_clk),
        .wr_pulse(wr_pulse),
        .rd_pulse(rd_pulse),
        .res_fall(res_fall),
        .cl_rise(cl_rise),
        .sel_s_reg(sel_s),
        .rs_s_reg(rs_s),
        .rd_s_reg(rd_s),
        .sel_d_reg(sel_d),
        .rs_d_reg(rs_d),
        .din_d_reg(din_d)
    );

    // slave halves drive zero, so the master row wins
    assign scan_row = row_bus[4:0] | row_bus[9:5];

    // ****************************************
    // column controller halves
    // ****************************************
    genvar h;
    genvar i;
    generate
        for (h = 0; h < 2; h = h + 1) begin : g_half
            reg [7:0] mem [0:`DCPW_RAM_WORDS-1];
            reg role_reg;
            reg role_done_reg;
            reg [1:0] page_reg;
            reg [6:0] col_reg;
            reg [4:0] start_reg;
            reg on_reg;
            reg adc_reg;
            reg duty_reg;
            reg [5:0] busy_reg;
            reg rflag_reg;
            reg [4:0] row_reg;
            reg tick_reg;
            wire strap;
            wire col_ok;
            wire wr_ok;
            wire [7:0] status;
            wire [7:0] cur_word;
            wire [4:0] line;
            wire [4:0] last_row;

            assign strap = (h == 0) ? `DCPW_LEFT_STRAP : `DCPW_RIGHT_STRAP;
            assign col_ok = (col_reg < `DCPW_COLS);
            assign wr_ok = wr_pulse & sel_d[h] & (busy_reg == 6'h00);
            assign last_row = duty_reg ? `DCPW_LAST_ROW_32 : `DCPW_LAST_ROW_16;

            // strap caught once, just after reset release
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    role_reg <= 1'b0;
                    role_done_reg <= 1'b0;
                end else if (!role_done_reg) begin
                    role_reg <= strap;
                    role_done_reg <= 1'b1;
                end
            end

            // instruction decode, address counters and busy timer
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    page_reg <= 2'h0;
                    col_reg <= 7'h00;
                    start_reg <= 5'h00;
                    on_reg <= 1'b0;
                    adc_reg <= 1'b0;
                    duty_reg <= 1'b0;
                    busy_reg <= 6'h00;
                    rflag_reg <= 1'b0;
                end else if (res_fall) begin
                    page_reg <= 2'h0;
                    col_reg <= 7'h00;
                    start_reg <= 5'h00;
                    on_reg <= 1'b0;
                    adc_reg <= 1'b0;
                    duty_reg <= 1'b0;
                    busy_reg <= RESET_LOAD;
                    rflag_reg <= 1'b1;
                end else begin
                    if (busy_reg != 6'h00) begin
                        busy_reg <= busy_reg - 6'h01;
                    end else begin
                        rflag_reg <= 1'b0;
                    end
                    if (wr_ok) begin
                        busy_reg <= BUSY_LOAD;
                        if (rs_d) begin
                            if (col_ok) begin
                                col_reg <= col_reg + 7'h01;
                            end
                        end else if (din_d[7:1] == `DCPW_OP_DISP) begin
                            on_reg <= din_d[0];
                        end else if (din_d[7:1] == `DCPW_OP_ADC) begin
                            adc_reg <= din_d[0];
                        end else if (din_d[7:1] == `DCPW_OP_DUTY) begin
                            duty_reg <= din_d[0];
                        end else if (din_d[7:2] == `DCPW_OP_PAGE) begin
                            page_reg <= din_d[1:0];
                        end else if (din_d[7:5] == `DCPW_OP_START) begin
                            start_reg <= din_d[4:0];
                        end else if (!din_d[7]) begin
                            col_reg <= din_d[6:0];
                        end
                    end else if (rd_pulse & sel_d[h] & rs_d & col_ok) begin
                        col_reg <= col_reg + 7'h01; // data reads step too
                    end
                end
            end

            // display memory write, one byte per page column
            always @(posedge core_clk) begin
                if (wr_ok & rs_d & col_ok) begin
                    mem[ram_idx(page_reg, col_reg)] <= din_d;
                end
            end

            // row scan, run only by the master half
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    row_reg <= 5'h00;
                    tick_reg <= 1'b0;
                end else begin
                    tick_reg <= 1'b0;
                    if (res_fall) begin
                        row_reg <= 5'h00;
                    end else if (role_reg & cl_rise) begin
                        tick_reg <= 1'b1;
                        if (row_reg >= last_row) begin
                            row_reg <= 5'h00;
                        end else begin
                            row_reg <= row_reg + 5'h01;
                        end
                    end
                end
            end

            assign row_bus[h*5 +: 5] = role_reg ? row_reg : 5'h00;
            assign tick_bus[h] = role_reg & tick_reg;

            // read answer: data byte or status byte
            assign status = {(busy_reg != 6'h00), adc_reg, ~on_reg,
                             rflag_reg, 4'h0};
            assign cur_word = col_ok ? mem[ram_idx(page_reg, col_reg)]
                                     : 8'h00;
            assign rd_bus[h*8 +: 8] = rs_s ? cur_word : status;

            // pixel output; page from upper line bits, row bit from lower
            assign line = scan_row + start_reg;
            for (i = 0; i < `DCPW_VIS_COLS; i = i + 1) begin : g_seg
                localparam [6:0] CI = i;
                wire [6:0] c;
                wire [7:0] w;
                assign c = adc_reg ? (`DCPW_COL_LAST - CI) : CI;
                assign w = mem[ram_idx(line[4:3], c)];
                assign seg_bus[h*`DCPW_VIS_COLS + i] = on_reg & w[line[2:0]];
            end
        end
    endgenerate

    // ****************************************
    // registered outputs
    // ****************************************
    // left half takes the bus when both are selected
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out_reg <= 8'h00;
            data_oe_reg <= 1'b0;
            common_row_reg <= 5'h00;
            row_strobe_reg <= 1'b0;
            seg_out_reg <= {122{1'b0}};
        end else begin
            data_oe_reg <= ~rd_s & (|sel_s);
            data_out_reg <= sel_s[0] ? rd_bus[7:0] : rd_bus[15:8];
            common_row_reg <= scan_row;
            row_strobe_reg <= |tick_bus;
            seg_out_reg <= seg_bus; // left half in the low bits
        end
    end
endmodule // dcpw_top

//--- test/dcpw_checker.sv
// checker on the page writer top ports: bus drive and row scan
// assumes bind into dcpw_top; single core_clk domain
`timescale 1ns/10ps
module dcpw_checker (
    input wire core_clk,
    input wire rst_n,
    input wire left_half_select_n,
    input wire right_half_select_n,
    input wire rd_n,
    input wire ext_clk,
    input wire data_oe_reg,
    input wire [4:0] common_row_reg,
    input wire row_strobe_reg
);
    // ****
    // bus and scan properties
    // ****
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // read held with a half selected
    sequence s_rd_held;
        (!rd_n && !(left_half_select_n && right_half_select_n)) [*3];
    endsequence
    // rising edge of the scan clock
    sequence s_clk_rise;
        !ext_clk ##1 ext_clk;
    endsequence
    a_oe_on_read: assert property (s_rd_held |-> data_oe_reg)
        else $error("bus not driven during read");
    a_oe_off_idle: assert property (rd_n [*3] |-> !data_oe_reg)
        else $error("bus driven without read");
    a_oe_no_select: assert property
        ((left_half_select_n && right_half_select_n) [*3] |-> !data_oe_reg)
        else $error("bus driven with no half selected");
    a_oe_has_cause: assert property (data_oe_reg |-> !$past(rd_n, 2))
        else $error("bus drive without earlier read");
    a_strobe_single: assert property (row_strobe_reg |=> !row_strobe_reg)
        else $error("row strobe longer than one cycle");
    a_row_steps_one: assert property (row_strobe_reg |->
        common_row_reg == $past(common_row_reg) + 5'h01 || common_row_reg == 5'h00)
        else $error("row did not step by one");
    a_row_holds: assert property
        (!row_strobe_reg && common_row_reg != 5'h00 |-> $stable(common_row_reg))
        else $error("row changed without strobe");
    a_step_after_clk: assert property (s_clk_rise |-> ##[1:4] row_strobe_reg)
        else $error("master did not step row on scan clock");
endmodule // dcpw_checker

bind dcpw_top dcpw_checker chk_u (.core_clk, .rst_n, .left_half_select_n,
    .right_half_select_n, .rd_n, .ext_clk, .data_oe_reg, .common_row_reg,
    .row_strobe_reg);

//--- test/dcpw_host_model.sv
// host model on the parallel bus: transfers and soft reset
// assumes pins change just after core_clk rising edges
`timescale 1ns/10ps
module dcpw_host_model (
    input wire core_clk,
    input wire [7:0] data_out_reg,
    input wire data_oe_reg,
    output reg left_half_select_n,
    output reg right_half_select_n,
    output reg register_select,
    output reg rd_n,
    output reg wr_n,
    output reg [7:0] data_in,
    output reg edge_reset_input
);
    // ****
    // bus cycles
    // ****
    // idle pins at time zero, reset pin held low
    initial begin
        {left_half_select_n, right_half_select_n, rd_n, wr_n} = 4'hF;
        register_select = 1'b0;
        data_in = 8'h00;
        edge_reset_input = 1'b0;
    end
    // one transfer; sel bit 1 left, bit 0 right; rd high reads
    task cyc(input [1:0] sel, input rs, input rd, input [7:0] d,
        output [7:0] q);
        begin
            @(posedge core_clk);
            {left_half_select_n, right_half_select_n} <= ~sel;
            register_select <= rs;
            data_in <= d;
            wr_n <= rd;
            rd_n <= ~rd;
            repeat (4) @(posedge core_clk);
            q = data_oe_reg ? data_out_reg : 8'hZZ;
            {wr_n, rd_n} <= 2'b11;
            @(posedge core_clk);
            {left_half_select_n, right_half_select_n} <= 2'b11;
            data_in <= ~d;
            repeat (24) @(posedge core_clk);
        end
    endtask
    // falling edge on the reset pin, then held low
    task soft_reset;
        begin
            @(posedge core_clk);
            edge_reset_input <= 1'b1;
            repeat (4) @(posedge core_clk);
            edge_reset_input <= 1'b0;
        end
    endtask
endmodule // dcpw_host_model

//--- test/dcpw_top_tb_top.sv
// bench for the page writer: fill, read back, scan, soft reset
// assumes dcpw_top, host model and checker compiled before
`timescale 1ns/10ps
`include "dcpw_map.vh"
module dcpw_top_tb_top;
    reg core_clk;
    reg rst_n;
    reg ext_clk;
    wire left_half_select_n, right_half_select_n, register_select;
    wire rd_n, wr_n, edge_reset_input, data_oe_reg, row_strobe_reg;
    wire [7:0] data_in;
    wire [7:0] data_out_reg;
    wire [4:0] common_row_reg;
    wire [121:0] seg_out_reg;
    reg [7:0] q;
    reg [1:0] sel;
    reg [121:0] exp_row;
    integer miscompares, tests_run, cycles, s, p, c, i;
    dcpw_top dut_u (.core_clk, .rst_n, .left_half_select_n,
        .right_half_select_n, .register_select, .rd_n, .wr_n, .data_in,
        .edge_reset_input, .ext_clk, .data_out_reg, .data_oe_reg,
        .common_row_reg, .row_strobe_reg, .seg_out_reg);
    dcpw_host_model host_u (.core_clk, .data_out_reg, .data_oe_reg,
        .left_half_select_n, .right_half_select_n, .register_select,
        .rd_n, .wr_n, .data_in, .edge_reset_input);
    // ****
    // clock, timeout and helpers
    // ****
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    task chk(input [121:0] got, input [121:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [1:0] sl, input rs, input [7:0] d);
        host_u.cyc(sl, rs, 1'b0, d, q);
    endtask
    // one half at a time on reads
    task rd(input [1:0] sl, input rs);
        host_u.cyc(sl, rs, 1'b1, 8'h00, q);
    endtask
    // scan clock pulse held four cycles
    task pulse;
        begin
            @(posedge core_clk);
            ext_clk <= 1'b1;
            repeat (4) @(posedge core_clk);
            ext_clk <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
    endtask
    function [7:0] pat(input sd, input [1:0] pg, input [6:0] col);
        pat = {col[5:0], pg} ^ {sd, 6'h15, 1'b1};
    endfunction
    // expected segment row: left cols then right cols
    function [121:0] rowvec(input [4:0] r);
        integer k;
        reg [7:0] a;
        reg [7:0] b;
        begin
            for (k = 0; k < 61; k = k + 1) begin
                a = pat(1'b0, r[4:3], k[6:0]);
                b = pat(1'b1, r[4:3], k[6:0]);
                rowvec[k] = a[r[2:0]];
                rowvec[61 + k] = b[r[2:0]];
            end
        end
    endfunction
    // ****
    // scenarios
    // ****
    task t_fill;
        begin
            rd(2'b10, 1'b0);
            chk(q, 8'h20);
            rd(2'b01, 1'b0);
            chk(q, 8'h20);
            wr(2'b11, 1'b0, 8'hA9);
            wr(2'b11, 1'b0, 8'hAF);
            for (s = 0; s < 2; s = s + 1)
                for (p = 0; p < 4; p = p + 1) begin
                    sel = s ? 2'b01 : 2'b10;
                    wr(sel, 1'b0, {`DCPW_OP_PAGE, p[1:0]});
                    wr(sel, 1'b0, 8'h00);
                    for (c = 0; c < `DCPW_VIS_COLS; c = c + 1)
                        wr(sel, 1'b1, pat(s[0], p[1:0], c[6:0]));
                end
        end
    endtask
    task t_readback;
        for (s = 0; s < 2; s = s + 1)
            for (p = 0; p < 4; p = p + 1) begin
                sel = s ? 2'b01 : 2'b10;
                wr(sel, 1'b0, {`DCPW_OP_PAGE, p[1:0]});
                wr(sel, 1'b0, 8'h00);
                rd(sel, 1'b1);
                chk(q, pat(s[0], p[1:0], 7'h00));
                rd(sel, 1'b1);
                chk(q, pat(s[0], p[1:0], 7'h01));
                wr(sel, 1'b0, 8'h3C);
                rd(sel, 1'b1);
                chk(q, pat(s[0], p[1:0], 7'h3C));
            end
    endtask
    // last column, then write and read past the end
    task t_col_limit;
        begin
            wr(2'b10, 1'b0, 8'h4F);
            wr(2'b10, 1'b1, 8'h3C);
            wr(2'b10, 1'b1, 8'hC3);
            wr(2'b10, 1'b0, 8'h4F);
            rd(2'b10, 1'b1);
            chk(q, 8'h3C);
            rd(2'b10, 1'b1);
            chk(q, 8'h00);
        end
    endtask
    task t_scan;
        for (i = 1; i <= 33; i = i + 1) begin
            pulse;
            chk(common_row_reg, i[4:0]);
            chk(seg_out_reg, rowvec(i[4:0]));
        end
    endtask
    // mirrored column order and a moved start line on both halves
    task t_adc_start;
        begin
            wr(2'b11, 1'b0, 8'hA1);
            rd(2'b10, 1'b0);
            chk(q, 8'h40);
            wr(2'b11, 1'b0, 8'hC8);
            pulse;
            exp_row = rowvec(5'h0A);
            chk(common_row_reg, 5'h02);
            chk(seg_out_reg[60], exp_row[19]);
            chk(seg_out_reg[121], exp_row[80]);
        end
    endtask
    task t_soft_reset;
        begin
            host_u.soft_reset;
            rd(2'b10, 1'b0);
            chk(q, 8'hB0);
            repeat (20) @(posedge core_clk);
            rd(2'b10, 1'b0);
            chk(q, 8'h20);
            pulse;
            chk(seg_out_reg, 122'h0);
        end
    endtask
    task final_report;
        begin
            $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // reset, then scenarios in order
    initial begin
        miscompares = 0;
        tests_run = 0;
        cycles = 0;
        rst_n = 1'b0;
        ext_clk = 1'b0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_fill;
        t_readback;
        t_col_limit;
        t_scan;
        t_adc_start;
        t_soft_reset;
        final_report;
    end
endmodule // dcpw_top_tb_top
